// ===== core/btar_consts.vh
// How it works
// - Sine frequency is superframe rate times M over N, integers.
// - Superframe rate is bus clock over 6144 bits.
// - Subframe mode plays no part in sine timing.
// - Channel whose sink is not the generator gets no sink behaviour.
// - Pulled sink channel: generator drives only the SRQ bit.
// - SRQ from file content, or fractional divider when sine sources.
// - Asynchronous sink channel: generator drives only the CTS bit.
// - Asynchronous sink: CTS always taken from file content.
// - Entry matches only its configured source address.
// - Type filter 0xFF accepts every message type.
// - Code filter 0xFF accepts every message code.
// - Matching message gets the entry's response code in its slot.
// - Counter limits custom answers; at zero, PACK if valid, else NACK.
// - Up to 15 filter and response entries.
// - Dynamic mode answers in hardware; static uses event sequence.
// - Enabled engine answers every message, default when no match.
// - Manager address 0xFF, NORE, counter zero silences own messages.
// - Response written with logical-OR signalling.
// - Response is a four-bit code in one slot.
`ifndef BTAR_CONSTS_VH
`define BTAR_CONSTS_VH
`define BTAR_SF_BITS      13'h1800
`define BTAR_ALL_FILTER   8'hFF
`define BTAR_MGR_LA       8'hFF
`define BTAR_RESP_NORE    4'h0
`define BTAR_RESP_PACK    4'hA
`define BTAR_RESP_NACK    4'h5
`define BTAR_N_ENTRIES    15
`define BTAR_REG_CTRL     12'h000
`define BTAR_REG_SINE_M   12'h004
`define BTAR_REG_SINE_N   12'h008
`define BTAR_REG_CHAN     12'h00C
`define BTAR_REG_RATE     12'h010
`define BTAR_REG_STATUS   12'h014
`define BTAR_REG_ENT_BASE 12'h040
`define BTAR_REG_ENT_END  12'h130
`define BTAR_CTRL_DYN     0
`define BTAR_CHAN_SINK    0
`define BTAR_CHAN_ASYNC   1
`define BTAR_CHAN_SINE    2
`define BTAR_ENT_ISEA     16
`define BTAR_ENT_VALID    31
`define BTAR_RST_SINE_M   16'h0001
`define BTAR_RST_SINE_N   16'h0002
`define BTAR_RST_RATE_PR  16'h0001
`define BTAR_RESP_OKAY    2'b00
`define BTAR_RESP_SLVERR  2'b10
`endif

// ===== core/btar_top.v
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "btar_consts.vh"
module btar_top #(
   parameter N_ENT = `BTAR_N_ENTRIES
) (
   input  wire        i_clock,
   input  wire        i_reset_n,
   input  wire [11:0] i_awaddr,
   input  wire        i_awvalid,
   output wire        o_awready,
   input  wire [31:0] i_wdata,
   input  wire [3:0]  i_wstrb,
   input  wire        i_wvalid,
   output wire        o_wready,
   output reg  [1:0]  o_bresp,
   output reg         o_bvalid,
   input  wire        i_bready,
   input  wire [11:0] i_araddr,
   input  wire        i_arvalid,
   output wire        o_arready,
   output reg  [31:0] o_rdata,
   output reg  [1:0]  o_rresp,
   output reg         o_rvalid,
   input  wire        i_rready,
   input  wire        i_bit_tick,
   input  wire        i_msg_valid,
   input  wire [47:0] i_msg_src,
   input  wire        i_msg_src_is_ea,
   input  wire [7:0]  i_msg_type,
   input  wire [7:0]  i_msg_code,
   input  wire        i_msg_crc_ok,
   input  wire        i_static_valid,
   input  wire [3:0]  i_static_resp,
   input  wire        i_seg_tick,
   input  wire        i_file_flow_bit,
   output reg         o_resp_valid,
   output reg  [3:0]  o_resp_out,
   output reg  [3:0]  o_resp_oe,
   output reg         o_flow_valid,
   output reg         o_flow_is_cts,
   output reg         o_flow_out,
   output reg         o_flow_oe,
   output reg         o_sf_start,
   output reg  [7:0]  o_sine_sample
);
   reg        dyn_ff;
   reg [15:0] sine_m_ff;
   reg [15:0] sine_n_ff;
   reg [2:0]  chan_ff;
   reg [15:0] rate_ch_ff;
   reg [15:0] rate_pr_ff;
   reg [31:0] ent_a_ff [0:N_ENT-1];
   reg [31:0] ent_b_ff [0:N_ENT-1];
   reg [31:0] ent_c_ff [0:N_ENT-1];
   reg [15:0] resp_cnt_ff;
   reg [12:0] bit_cnt_ff;
   reg [31:0] phase_ff;
   reg [15:0] frac_ff;
   reg [3:0]  hit_idx;
   reg        hit;
   reg [3:0]  nxt_resp;
   reg [3:0]  seg_idx;
   reg [31:0] nxt_phase;
   reg [16:0] nxt_frac;
   reg [35:0] seg_thr;
   wire [31:0] phase_mod;
   wire        wr_go;
   wire        rd_go;
   wire [3:0]  w_ent;
   wire [1:0]  w_word;
   wire        w_in_ent;
   wire [3:0]  r_ent;
   wire [1:0]  r_word;
   wire        r_in_ent;
   integer     k;
   integer     j;
   integer     m;

   function [7:0] sine_lut;
      input [3:0] idx;
      begin
         case (idx)
            4'h0: sine_lut = 8'h00;
            4'h1: sine_lut = 8'h31;
            4'h2: sine_lut = 8'h5A;
            4'h3: sine_lut = 8'h76;
            4'h4: sine_lut = 8'h7F;
            4'h5: sine_lut = 8'h76;
            4'h6: sine_lut = 8'h5A;
            4'h7: sine_lut = 8'h31;
            4'h8: sine_lut = 8'h00;
            4'h9: sine_lut = 8'hCF;
            4'hA: sine_lut = 8'hA6;
            4'hB: sine_lut = 8'h8A;
            4'hC: sine_lut = 8'h81;
            4'hD: sine_lut = 8'h8A;
            4'hE: sine_lut = 8'hA6;
            default: sine_lut = 8'hCF;
         endcase
      end
   endfunction

   function ent_hit;
      input [47:0] src;
      input        is_ea;
      input [31:0] wa;
      input [31:0] wb;
      input [31:0] wc;
      input [7:0]  mtype;
      input [7:0]  mcode;
      reg          addr_ok;
      begin
         if (wc[`BTAR_ENT_ISEA])
            addr_ok = is_ea && (wa == src[31:0]) && (wb[15:0] == src[47:32]);
         else
            addr_ok = !is_ea && (wa[7:0] == src[7:0]);
         ent_hit = wc[`BTAR_ENT_VALID] && addr_ok
            && ((wb[23:16] == `BTAR_ALL_FILTER) || (wb[23:16] == mtype))
            && ((wb[31:24] == `BTAR_ALL_FILTER) || (wb[31:24] == mcode));
      end
   endfunction

   assign wr_go     = i_awvalid && i_wvalid && !o_bvalid;
   assign o_awready = wr_go;
   assign o_wready  = wr_go;
   assign rd_go     = i_arvalid && !o_rvalid;
   assign o_arready = rd_go;
   assign w_in_ent  = (i_awaddr >= `BTAR_REG_ENT_BASE) && (i_awaddr < `BTAR_REG_ENT_END)
                      && (i_awaddr[3:2] != 2'b11);
   assign w_ent     = i_awaddr[7:4] - 4'h4;
   assign w_word    = i_awaddr[3:2];
   assign r_in_ent  = (i_araddr >= `BTAR_REG_ENT_BASE) && (i_araddr < `BTAR_REG_ENT_END)
                      && (i_araddr[3:2] != 2'b11);
   assign r_ent     = i_araddr[7:4] - 4'h4;
   assign r_word    = i_araddr[3:2];

   // Lowest matching entry, decision on the response code
   always @* begin
      hit_idx = 4'h0;
      hit     = 1'b0;
      for (k = N_ENT - 1; k >= 0; k = k - 1) begin
         if (ent_hit(i_msg_src, i_msg_src_is_ea, ent_a_ff[k], ent_b_ff[k], ent_c_ff[k],
                     i_msg_type, i_msg_code)) begin
            hit     = 1'b1;
            hit_idx = k[3:0];
         end
      end
      if (hit && (ent_c_ff[hit_idx][15:8] != 8'h00 || ent_c_ff[hit_idx][3:0] == `BTAR_RESP_NORE))
         nxt_resp = ent_c_ff[hit_idx][3:0];
      else if (i_msg_crc_ok)
         nxt_resp = `BTAR_RESP_PACK;
      else
         nxt_resp = `BTAR_RESP_NACK;
   end

   // Register bus, entries and counters
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dyn_ff     <= 1'b0;
         sine_m_ff  <= `BTAR_RST_SINE_M;
         sine_n_ff  <= `BTAR_RST_SINE_N;
         chan_ff    <= 3'b000;
         rate_ch_ff <= 16'h0000;
         rate_pr_ff <= `BTAR_RST_RATE_PR;
         o_bvalid   <= 1'b0;
         o_bresp    <= `BTAR_RESP_OKAY;
         o_rvalid   <= 1'b0;
         o_rresp    <= `BTAR_RESP_OKAY;
         o_rdata    <= 32'h0000_0000;
         for (j = 0; j < N_ENT; j = j + 1) begin
            ent_a_ff[j] <= 32'h0000_0000;
            ent_b_ff[j] <= 32'h0000_0000;
            ent_c_ff[j] <= 32'h0000_0000;
         end
      end else begin
         if (o_bvalid && i_bready)
            o_bvalid <= 1'b0;
         if (o_rvalid && i_rready)
            o_rvalid <= 1'b0;
         if (i_msg_valid && dyn_ff && hit && ent_c_ff[hit_idx][15:8] != 8'h00)
            ent_c_ff[hit_idx][15:8] <= ent_c_ff[hit_idx][15:8] - 8'h01;
         if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp  <= `BTAR_RESP_OKAY;
            if (w_in_ent && w_word == 2'b00)
               ent_a_ff[w_ent] <= i_wdata;
            else if (w_in_ent && w_word == 2'b01)
               ent_b_ff[w_ent] <= i_wdata;
            else if (w_in_ent)
               ent_c_ff[w_ent] <= i_wdata;
            else if (i_awaddr == `BTAR_REG_CTRL)
               dyn_ff <= i_wdata[`BTAR_CTRL_DYN];
            else if (i_awaddr == `BTAR_REG_SINE_M)
               sine_m_ff <= i_wdata[15:0];
            else if (i_awaddr == `BTAR_REG_SINE_N)
               sine_n_ff <= i_wdata[15:0];
            else if (i_awaddr == `BTAR_REG_CHAN)
               chan_ff <= i_wdata[2:0];
            else if (i_awaddr == `BTAR_REG_RATE) begin
               rate_ch_ff <= i_wdata[15:0];
               rate_pr_ff <= i_wdata[31:16];
            end else if (i_awaddr != `BTAR_REG_STATUS)
               o_bresp <= `BTAR_RESP_SLVERR;
         end
         if (rd_go) begin
            o_rvalid <= 1'b1;
            o_rresp  <= `BTAR_RESP_OKAY;
            if (r_in_ent && r_word == 2'b00)
               o_rdata <= ent_a_ff[r_ent];
            else if (r_in_ent && r_word == 2'b01)
               o_rdata <= ent_b_ff[r_ent];
            else if (r_in_ent)
               o_rdata <= ent_c_ff[r_ent];
            else if (i_araddr == `BTAR_REG_CTRL)
               o_rdata <= {31'h0000_0000, dyn_ff};
            else if (i_araddr == `BTAR_REG_SINE_M)
               o_rdata <= {16'h0000, sine_m_ff};
            else if (i_araddr == `BTAR_REG_SINE_N)
               o_rdata <= {16'h0000, sine_n_ff};
            else if (i_araddr == `BTAR_REG_CHAN)
               o_rdata <= {29'h0000_0000, chan_ff};
            else if (i_araddr == `BTAR_REG_RATE)
               o_rdata <= {rate_pr_ff, rate_ch_ff};
            else if (i_araddr == `BTAR_REG_STATUS)
               o_rdata <= {12'h000, o_resp_out, resp_cnt_ff};
            else begin
               o_rdata <= 32'h0000_0000;
               o_rresp <= `BTAR_RESP_SLVERR;
            end
         end
      end
   end

   // Response slot drive, wired-OR onto the slot
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_resp_valid <= 1'b0;
         o_resp_out   <= 4'h0;
         o_resp_oe    <= 4'h0;
         resp_cnt_ff  <= 16'h0000;
      end else begin
         o_resp_valid <= 1'b0;
         o_resp_oe    <= 4'h0;
         if (dyn_ff && i_msg_valid) begin
            o_resp_valid <= 1'b1;
            o_resp_out   <= nxt_resp;
            o_resp_oe    <= nxt_resp;
            resp_cnt_ff  <= resp_cnt_ff + 16'h0001;
         end else if (!dyn_ff && i_static_valid) begin
            o_resp_valid <= 1'b1;
            o_resp_out   <= i_static_resp;
            o_resp_oe    <= i_static_resp;
         end
      end
   end

   // Superframe counter and sine phase
   assign phase_mod = sine_n_ff * {19'h0_0000, `BTAR_SF_BITS};
   always @* begin
      nxt_phase = phase_ff + {16'h0000, sine_m_ff};
      if (nxt_phase >= phase_mod)
         nxt_phase = nxt_phase - phase_mod;
      seg_idx = 4'h0;
      seg_thr = 36'h0_0000_0000;
      for (m = 1; m < 16; m = m + 1) begin
         seg_thr = seg_thr + {4'h0, phase_mod};
         if ({phase_ff, 4'h0} >= seg_thr)
            seg_idx = m[3:0];
      end
   end

   // Fractional divider for sample spread
   always @* begin
      nxt_frac = {1'b0, frac_ff} + {1'b0, rate_ch_ff};
   end

   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bit_cnt_ff    <= 13'h0000;
         o_sf_start    <= 1'b0;
         phase_ff      <= 32'h0000_0000;
         o_sine_sample <= 8'h00;
         frac_ff       <= 16'h0000;
         o_flow_valid  <= 1'b0;
         o_flow_is_cts <= 1'b0;
         o_flow_out    <= 1'b0;
         o_flow_oe     <= 1'b0;
      end else begin
         o_sf_start <= 1'b0;
         if (i_bit_tick) begin
            if (bit_cnt_ff == `BTAR_SF_BITS - 13'h0001) begin
               bit_cnt_ff <= 13'h0000;
               o_sf_start <= 1'b1;
            end else
               bit_cnt_ff <= bit_cnt_ff + 13'h0001;
            phase_ff <= (phase_mod == 32'h0000_0000) ? 32'h0000_0000 : nxt_phase;
         end
         o_sine_sample <= sine_lut(seg_idx);
         o_flow_valid  <= 1'b0;
         o_flow_oe     <= 1'b0;
         if (i_seg_tick && chan_ff[`BTAR_CHAN_SINK]) begin
            o_flow_valid  <= 1'b1;
            o_flow_oe     <= 1'b1;
            o_flow_is_cts <= chan_ff[`BTAR_CHAN_ASYNC];
            if (chan_ff[`BTAR_CHAN_ASYNC])
               o_flow_out <= i_file_flow_bit;
            else if (!chan_ff[`BTAR_CHAN_SINE])
               o_flow_out <= i_file_flow_bit;
            else if (nxt_frac >= {1'b0, rate_pr_ff}) begin
               o_flow_out <= 1'b1;
               frac_ff    <= nxt_frac[15:0] - rate_pr_ff;
            end else begin
               o_flow_out <= 1'b0;
               frac_ff    <= nxt_frac[15:0];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== verification/btar_checker.sv
`timescale 1ns/100ps
`default_nettype none
module btar_checker (
   input wire logic       i_clock,
   input wire logic       i_reset_n,
   input wire logic       i_bit_tick,
   input wire logic       i_msg_valid,
   input wire logic       i_static_valid,
   input wire logic [3:0] i_static_resp,
   input wire logic       i_seg_tick,
   input wire logic       i_file_flow_bit,
   input wire logic       o_resp_valid,
   input wire logic [3:0] o_resp_out,
   input wire logic [3:0] o_resp_oe,
   input wire logic       o_flow_valid,
   input wire logic       o_flow_is_cts,
   input wire logic       o_flow_out,
   input wire logic       o_flow_oe,
   input wire logic       o_sf_start
);
   logic [12:0] cnt_ff;
   logic        hit_ff;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   // Bit position within the superframe
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_ff <= 13'h0000;
         hit_ff <= 1'b0;
      end else begin
         hit_ff <= i_bit_tick && (cnt_ff == 13'h17FF);
         if (i_bit_tick)
            cnt_ff <= (cnt_ff == 13'h17FF) ? 13'h0000 : cnt_ff + 13'h0001;
      end
   end
   property p_cause; o_resp_valid |-> $past(i_msg_valid || i_static_valid); endproperty
   a_cause: assert property (p_cause) else $error("response with no request");
   property p_oe; o_resp_valid |-> o_resp_oe == o_resp_out; endproperty
   a_oe: assert property (p_oe) else $error("drive enable not the code");
   property p_idle; !o_resp_valid |-> o_resp_oe == 4'h0; endproperty
   a_idle: assert property (p_idle) else $error("slot driven outside response");
   property p_stat; o_resp_valid && !$past(i_msg_valid) |-> o_resp_out == $past(i_static_resp); endproperty
   a_stat: assert property (p_stat) else $error("static code wrong");
   property p_flow; o_flow_valid |-> $past(i_seg_tick); endproperty
   a_flow: assert property (p_flow) else $error("flow bit out of segment");
   property p_foe; o_flow_oe == o_flow_valid; endproperty
   a_foe: assert property (p_foe) else $error("flow drive mismatch");
   property p_cts; o_flow_valid && o_flow_is_cts |-> o_flow_out == $past(i_file_flow_bit); endproperty
   a_cts: assert property (p_cts) else $error("clear to send not from file");
   property p_sf; o_sf_start == hit_ff; endproperty
   a_sf: assert property (p_sf) else $error("superframe start misplaced");
   c_resp: cover property (o_resp_valid && o_resp_out == 4'h5);
   c_cts: cover property (o_flow_valid && o_flow_is_cts);
   c_sf: cover property (o_sf_start);
   c_srq: cover property (o_flow_valid && !o_flow_is_cts && o_flow_out);
endmodule
bind btar_top btar_checker u_chk (
   .i_clock, .i_reset_n, .i_bit_tick, .i_msg_valid, .i_static_valid, .i_static_resp,
   .i_seg_tick, .i_file_flow_bit, .o_resp_valid, .o_resp_out, .o_resp_oe,
   .o_flow_valid, .o_flow_is_cts, .o_flow_out, .o_flow_oe, .o_sf_start
);
`default_nettype wire

// ===== verification/btar_peer.sv
`timescale 1ns/100ps
`default_nettype none
module btar_peer (
   input  wire logic        i_clock,
   output var  logic        o_bit_tick,
   output var  logic        o_msg_valid,
   output var  logic [47:0] o_msg_src,
   output var  logic        o_msg_src_is_ea,
   output var  logic [7:0]  o_msg_type,
   output var  logic [7:0]  o_msg_code,
   output var  logic        o_msg_crc_ok
);
   initial begin
      o_bit_tick = 1'b0;
      {o_msg_valid, o_msg_src, o_msg_src_is_ea, o_msg_type, o_msg_code, o_msg_crc_ok} = '0;
   end
   // One bus bit per clock
   always @(posedge i_clock)
      o_bit_tick <= 1'b1;
   // One message, fields scrambled after
   task automatic send(input logic [47:0] s, input logic e, input logic [7:0] t, c,
         input logic k);
      @(posedge i_clock);
      o_msg_valid <= 1'b1;
      {o_msg_src, o_msg_src_is_ea, o_msg_type, o_msg_code, o_msg_crc_ok} <= {s, e, t, c, k};
      @(posedge i_clock);
      o_msg_valid <= 1'b0;
      {o_msg_src, o_msg_src_is_ea, o_msg_type, o_msg_code, o_msg_crc_ok} <= ~{s, e, t, c, k};
   endtask
endmodule
`default_nettype wire

// ===== verification/bus_traffic_auto_responder_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "btar_consts.vh"
module bus_traffic_auto_responder_bench;
   logic        i_clock = 1'b0;
   logic        i_reset_n = 1'b0;
   logic [11:0] aw = '0, ar = '0;
   logic [31:0] wd = '0, d, x = 32'h0000_78a8;
   logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic        stv = 1'b0, seg = 1'b0, ffb = 1'b0;
   logic [3:0]  str = 4'h0;
   logic [1:0]  r;
   logic [7:0]  s0;
   wire         awr, wr_r, bv, arr, rv, tk, mv, ea, ok, rsv, fv, fc, fo, foe, sfs;
   wire  [1:0]  br, rr;
   wire  [31:0] rd;
   wire  [47:0] src;
   wire  [7:0]  mt, mc, sin;
   wire  [3:0]  rso, rsoe;
   int          n_errors = 0, num_checks = 0, cyc = 0, t0, acc;
   logic [31:0] cf [4] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0002, 32'h0000_0003};
   btar_top u_dut (
      .i_clock(i_clock), .i_reset_n(i_reset_n), .i_awaddr(aw), .i_awvalid(awv),
      .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wr_r),
      .o_bresp(br), .o_bvalid(bv), .i_bready(bry), .i_araddr(ar), .i_arvalid(arv),
      .o_arready(arr), .o_rdata(rd), .o_rresp(rr), .o_rvalid(rv), .i_rready(rry),
      .i_bit_tick(tk), .i_msg_valid(mv), .i_msg_src(src), .i_msg_src_is_ea(ea),
      .i_msg_type(mt), .i_msg_code(mc), .i_msg_crc_ok(ok), .i_static_valid(stv),
      .i_static_resp(str), .i_seg_tick(seg), .i_file_flow_bit(ffb), .o_resp_valid(rsv),
      .o_resp_out(rso), .o_resp_oe(rsoe), .o_flow_valid(fv), .o_flow_is_cts(fc),
      .o_flow_out(fo), .o_flow_oe(foe), .o_sf_start(sfs), .o_sine_sample(sin));
   btar_peer u_peer (.i_clock(i_clock), .o_bit_tick(tk), .o_msg_valid(mv), .o_msg_src(src),
      .o_msg_src_is_ea(ea), .o_msg_type(mt), .o_msg_code(mc), .o_msg_crc_ok(ok));
   always #25 i_clock = ~i_clock;
   always @(posedge i_clock)
      cyc <= cyc + 1;
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   function automatic logic [3:0] dflt(input logic k);
      return k ? `BTAR_RESP_PACK : `BTAR_RESP_NACK;
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge i_clock);
      {aw, wd, awv, wv} <= {a, v, 2'b11};
      @(posedge i_clock iff (awr && wr_r));
      {awv, wv, bry} <= 3'b001;
      @(posedge i_clock iff bv);
      bry <= 1'b0;
   endtask
   task automatic rdt(input logic [11:0] a);
      @(posedge i_clock);
      {ar, arv} <= {a, 1'b1};
      @(posedge i_clock iff arr);
      {arv, rry} <= 2'b01;
      @(posedge i_clock iff rv);
      {d, r} = {rd, rr};
      rry <= 1'b0;
   endtask
   task automatic ent(input int i, input logic [31:0] w0, w1, w2);
      wr(`BTAR_REG_ENT_BASE + 12'(16 * i), w0);
      wr(`BTAR_REG_ENT_BASE + 12'(16 * i + 4), w1);
      wr(`BTAR_REG_ENT_BASE + 12'(16 * i + 8), w2);
   endtask
   task automatic msg(input logic [47:0] s, input logic e, input logic [7:0] t, c,
         input logic k, input logic v, input logic [3:0] want);
      u_peer.send(s, e, t, c, k);
      #1;
      chk("resp_valid", v, rsv);
      if (v)
         chk("resp_code", want, rso);
   endtask
   task automatic pulse(input logic [3:0] v, input logic [31:0] c);
      @(posedge i_clock);
      {stv, seg, str, ffb} <= {~c[2], c[2], v, v[0] ^ c[3]};
      @(posedge i_clock);
      {stv, seg, str, ffb} <= {2'b00, ~v, ~v[0]};
      #1;
      chk("out_valid", c[2] ? c[0] : 1'b1, c[2] ? fv : rsv);
      if (!c[2])
         chk("static_code", v, rso);
      else if (c[0])
         chk("flow", {c[1], v[0]}, {fc, fo});
   endtask
   task automatic sfw;
      do begin
         @(posedge i_clock);
         #1;
      end while (sfs !== 1'b1);
   endtask
   initial begin
      repeat (5) @(posedge i_clock);
      i_reset_n <= 1'b1;
      rdt(`BTAR_REG_SINE_M);
      chk("sine_m", 32'h0000_0001, d);
      rdt(`BTAR_REG_SINE_N);
      chk("sine_n", 32'h0000_0002, d);
      rdt(`BTAR_REG_ENT_END);
      chk("unmapped_data", 32'h0000_0000, d);
      chk("unmapped_resp", `BTAR_RESP_SLVERR, r);
      wr(`BTAR_REG_CTRL, 32'h0000_0001);
      for (int k = 0; k < 8; k++) begin
         x = xs(x);
         msg({16'h0000, x}, x[0], x[15:8], x[23:16], x[4], 1'b1, dflt(x[4]));
      end
      ent(0, 32'h0000_0012, 32'hFFFF_0000, 32'h8000_0203);
      ent(1, 32'h0000_00FF, 32'hFFFF_0000, 32'h8000_0000);
      ent(2, 32'h0000_0030, 32'hFFFF_0000, 32'h8000_0106);
      ent(3, 32'h0000_0030, 32'hFFFF_0000, 32'h8000_0109);
      ent(14, 32'h4567_89AB, 32'h0100_0123, 32'h8001_0105);
      x = xs(x);
      msg(48'h12, 1'b1, x[7:0], x[15:8], 1'b1, 1'b1, `BTAR_RESP_PACK);
      msg(48'h13, 1'b0, x[7:0], x[15:8], 1'b1, 1'b1, `BTAR_RESP_PACK);
      msg(48'h12, 1'b0, x[7:0], x[15:8], 1'b1, 1'b1, 4'h3);
      msg(48'h12, 1'b0, x[23:16], x[31:24], 1'b0, 1'b1, 4'h3);
      msg(48'h12, 1'b0, x[7:0], x[15:8], 1'b1, 1'b1, `BTAR_RESP_PACK);
      msg(48'h12, 1'b0, x[7:0], x[15:8], 1'b0, 1'b1, `BTAR_RESP_NACK);
      msg(48'hFF, 1'b0, x[7:0], x[15:8], 1'b1, 1'b1, `BTAR_RESP_NORE);
      msg(48'h30, 1'b0, x[7:0], x[15:8], 1'b1, 1'b1, 4'h6);
      msg(48'h0123_4567_89AB, 1'b1, 8'h00, 8'h02, 1'b1, 1'b1, `BTAR_RESP_PACK);
      msg(48'h0123_4567_89AB, 1'b1, 8'h01, 8'h01, 1'b1, 1'b1, `BTAR_RESP_PACK);
      msg(48'h0123_4567_89AB, 1'b1, 8'h00, 8'h01, 1'b1, 1'b1, `BTAR_RESP_NACK);
      msg(48'h0123_4567_89AB, 1'b1, 8'h00, 8'h01, 1'b1, 1'b1, `BTAR_RESP_PACK);
      rdt(`BTAR_REG_STATUS);
      chk("status", {12'h000, `BTAR_RESP_PACK, 16'h0014}, d);
      wr(`BTAR_REG_CTRL, 32'h0000_0000);
      msg(48'h12, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 4'h0);
      for (int k = 0; k < 16; k++)
         pulse(4'(k), 32'h0000_0000);
      foreach (cf[k]) begin
         wr(`BTAR_REG_CHAN, cf[k]);
         for (int b = 0; b < 2; b++)
            pulse(4'(b), cf[k] | 32'h0000_0004);
      end
      wr(`BTAR_REG_RATE, 32'h0003_0001);
      wr(`BTAR_REG_CHAN, 32'h0000_0005);
      acc = 0;
      for (int b = 0; b < 6; b++) begin
         acc = acc + 1;
         pulse(4'(acc >= 3), 32'h0000_000D);
         if (acc >= 3)
            acc = acc - 3;
      end
      sfw();
      t0 = cyc;
      s0 = sin;
      sfw();
      chk("sf_period", `BTAR_SF_BITS, cyc - t0);
      sfw();
      chk("sine_repeat", s0, sin);
      end_of_test();
   end
   initial begin
      repeat (40000) @(posedge i_clock);
      n_errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
